// File: pkg/mvic_pkg.sv
/*
 Shared constants and types for the vectored nested interrupt controller:
 source and vector counts, vector addresses, source-to-vector masks,
 level encoding and the packed carriers between the controller and its
 neighbours. Assumes a single system clock domain.
*/
package mvic_pkg;

   localparam int SRC_N      = 24;
   localparam int VEC_N      = 10;
   localparam int EXT_N      = 6;
   localparam int VEC_ADDR_W = 20;
   localparam int VEC_IDX_W  = 4;
   localparam int LVL_N      = 3;

   typedef enum logic [1:0] {
      MVIC_LVL_NONE,
      MVIC_LVL_LOW,
      MVIC_LVL_HIGH,
      MVIC_LVL_HIGHEST
   } mvic_level_type;

   // Vector addresses, index 0 is the smallest address
   localparam logic [VEC_N-1:0][VEC_ADDR_W-1:0] VEC_ADDR = {
      20'h0004b, 20'h00043, 20'h0003b, 20'h00033, 20'h0002b,
      20'h00023, 20'h0001b, 20'h00013, 20'h0000b, 20'h00003
   };

   // Source flag bit positions
   localparam int SRC_EXT0   = 0;
   localparam int SRC_EXT1   = 1;
   localparam int SRC_EXT2   = 2;
   localparam int SRC_T0L    = 3;
   localparam int SRC_EXT4   = 4;
   localparam int SRC_REMOTE = 5;
   localparam int SRC_EXT3   = 6;
   localparam int SRC_EXT5   = 7;
   localparam int SRC_BT_A   = 8;
   localparam int SRC_BT_B   = 9;
   localparam int SRC_T0H    = 10;
   localparam int SRC_T1L    = 11;
   localparam int SRC_T1H    = 12;
   localparam int SRC_SYNC_SERIAL_ZERO_EVENT   = 13;
   localparam int SRC_ARX    = 14;
   localparam int SRC_SERIAL_ONE_EVENT   = 15;
   localparam int SRC_ATX    = 16;
   localparam int SRC_ADC    = 17;
   localparam int SRC_T6     = 18;
   localparam int SRC_T7     = 19;
   localparam int SRC_PORT0  = 20;
   localparam int SRC_T4     = 21;
   localparam int SRC_T5     = 22;
   localparam int SRC_PWM    = 23;

   // Which source flags belong to each vector
   localparam logic [VEC_N-1:0][SRC_N-1:0] VEC_MASK = {
      24'hf00000, 24'h0e0000, 24'h018000, 24'h006000, 24'h001800,
      24'h000400, 24'h0003c0, 24'h00003c, 24'h000002, 24'h000001
   };

   // Vectors whose upper level is highest rather than high
   localparam logic [VEC_N-1:0] VEC_TOP_X = 10'h003;

   localparam logic [SRC_N-1:0] FLAGS_RST = 24'h000000;

   typedef struct packed {
      logic zero;
      logic one;
      logic two;
      logic three;
      logic four;
      logic five;
   } mvic_ext_type;

   typedef struct packed {
      logic timer_zero_low_event;
      logic timer_zero_high_event;
      logic timer_one_low_event;
      logic timer_one_high_event;
      logic remote_receive_event;
      logic base_timer_event_a;
      logic base_timer_event_b;
      logic sync_serial_zero_event;
      logic async_serial_event_rx;
      logic serial_one_event;
      logic async_serial_event_tx;
      logic adc_event;
      logic timer_four_event;
      logic timer_five_event;
      logic timer_six_event;
      logic timer_seven_event;
      logic port_zero_event;
      logic pulse_width_chan_a_event;
      logic pulse_width_chan_b_event;
   } mvic_events_type;

   typedef struct packed {
      logic                  req;
      mvic_level_type        level;
      logic [VEC_ADDR_W-1:0] vec_addr;
   } mvic_core_req_type;

   function automatic mvic_level_type vec_level(input int v,
                                                input logic upper);
      if (!upper) begin
         return MVIC_LVL_LOW;
      end
      return VEC_TOP_X[v] ? MVIC_LVL_HIGHEST : MVIC_LVL_HIGH;
   endfunction

   function automatic mvic_level_type top_level(input logic [2:0] svc);
      if (svc[2]) begin
         return MVIC_LVL_HIGHEST;
      end
      if (svc[1]) begin
         return MVIC_LVL_HIGH;
      end
      if (svc[0]) begin
         return MVIC_LVL_LOW;
      end
      return MVIC_LVL_NONE;
   endfunction

endpackage

// File: rtl/mvic_arb.sv
/*
 Combinational arbiter: picks the best pending vector by level, then by
 smallest vector address, and offers it only above the level in service.
 Assumes flags and settings come from registers on the same clock.
*/
`timescale 1ns/1ps
module mvic_arb (
   input  wire logic [mvic_pkg::SRC_N-1:0]     i_flags,
   input  wire logic [mvic_pkg::VEC_N-1:0]     i_level_sel,
   input  wire mvic_pkg::mvic_level_type       i_cur_level,
   output logic                                o_valid,
   output logic [mvic_pkg::VEC_IDX_W-1:0]      o_vec_idx,
   output mvic_pkg::mvic_level_type            o_level
);
   import mvic_pkg::*;

   always_comb begin
      mvic_level_type best;
      mvic_level_type lv;
      logic [VEC_IDX_W-1:0] idx;
      best = MVIC_LVL_NONE;
      lv   = MVIC_LVL_NONE;
      idx  = '0;
      // Walk down so an equal level at a smaller address overrides
      for (int v = VEC_N - 1; v >= 0; v--) begin
         lv = vec_level(v, i_level_sel[v]);
         if (|(i_flags & VEC_MASK[v]) && lv >= best) begin
            best = lv;
            idx  = VEC_IDX_W'(v);
         end
      end
      o_valid   = (best != MVIC_LVL_NONE) && (best > i_cur_level);
      o_vec_idx = idx;
      o_level   = best;
   end

endmodule

// File: rtl/mvic_top.sv
/*
 Vectored three-level nested interrupt controller. Gathers the peripheral
 events and the external pins into sticky source flags, picks one vector
 and hands it to the core, keeps the stack of levels in service and the
 listing of flags behind the last taken vector.
 Assumes peripheral events, flag clears and core strobes are on the same
 clock; external pins are asynchronous and are synchronised here.
*/
// Notes on behaviour
// - 24 sources grouped onto 10 vectors
// - Levels low, high, highest, strictly ordered
// - Only strictly higher level may nest
// - Simultaneous vectors: highest level served first
// - Equal level: smallest vector address wins
// - Pins zero, one: own vectors, highest/low
// - Vector 13H shares four sources, high/low
// - Vector 1BH shares four sources, high/low
// - Timer vectors 23H, 2BH, 43H, high/low
// - Vector 33H: sync serial, async receive
// - Vector 3BH: serial one, async transmit
// - Vector 4BH: port, timers, pulse width
// - Readable listing of flags behind branch
// - Pins zero, one wake hold only level-mode
`timescale 1ns/1ps
module mvic_top (
   input  wire logic                           i_ref_clk,
   input  wire logic                           i_resetn,
   input  wire mvic_pkg::mvic_ext_type         i_ext_pins,
   input  wire logic [1:0]                     i_ext_level_mode,
   input  wire mvic_pkg::mvic_events_type      i_events,
   input  wire logic [mvic_pkg::VEC_N-1:0]     i_level_sel,
   input  wire logic [mvic_pkg::SRC_N-1:0]     i_flag_clr,
   input  wire logic                           i_irq_ack,
   input  wire logic                           i_irq_return,
   input  wire logic                           i_hold_mode,
   output mvic_pkg::mvic_core_req_type         o_core,
   output logic [mvic_pkg::SRC_N-1:0]          o_source_flag_listing,
   output logic [mvic_pkg::SRC_N-1:0]          o_flags,
   output logic [mvic_pkg::LVL_N-1:0]          o_in_service,
   output logic                                o_hold_wake
);
   import mvic_pkg::*;

   typedef struct packed {
      logic [EXT_N-1:0]     sync1;
      logic [EXT_N-1:0]     sync2;
      logic [EXT_N-1:0]     prev;
      logic [SRC_N-1:0]     flags;
      logic [LVL_N-1:0]     svc;
      mvic_core_req_type    core;
      logic [VEC_IDX_W-1:0] vec_idx;
      logic [SRC_N-1:0]     listing;
      logic                 wake;
   } mvic_state_type;

   localparam mvic_state_type STATE_RST = '{
      sync1:   '0,
      sync2:   '0,
      prev:    '0,
      flags:   FLAGS_RST,
      svc:     '0,
      core:    '{req: 1'b0, level: MVIC_LVL_NONE, vec_addr: '0},
      vec_idx: '0,
      listing: '0,
      wake:    1'b0
   };

   mvic_state_type state_q;
   mvic_state_type state_d;

   logic                 arb_valid;
   logic [VEC_IDX_W-1:0] arb_idx;
   mvic_level_type       arb_level;

   mvic_arb u_arb (
      .i_flags     (state_q.flags),
      .i_level_sel (i_level_sel),
      .i_cur_level (top_level(state_q.svc)),
      .o_valid     (arb_valid),
      .o_vec_idx   (arb_idx),
      .o_level     (arb_level)
   );

   always_comb begin
      logic [EXT_N-1:0] pin;
      logic [EXT_N-1:0] rise;
      logic [SRC_N-1:0] set;
      logic [LVL_N-1:0] svc;
      mvic_level_type   cur;
      pin     = '0;
      rise    = '0;
      set     = '0;
      svc     = '0;
      cur     = MVIC_LVL_NONE;
      state_d = state_q;

      // Pins cross into the clock domain through two flops
      state_d.sync1 = i_ext_pins;
      state_d.sync2 = state_q.sync1;
      state_d.prev  = state_q.sync2;
      pin  = state_q.sync2;
      rise = state_q.sync2 & ~state_q.prev;

      // Pins zero and one may be level or edge detected; others are edge
      set[SRC_EXT0]   = i_ext_level_mode[0] ? pin[5] : rise[5];
      set[SRC_EXT1]   = i_ext_level_mode[1] ? pin[4] : rise[4];
      set[SRC_EXT2]   = rise[3];
      set[SRC_T0L]    = i_events.timer_zero_low_event;
      set[SRC_EXT4]   = rise[1];
      set[SRC_REMOTE] = i_events.remote_receive_event;
      set[SRC_EXT3]   = rise[2];
      set[SRC_EXT5]   = rise[0];
      set[SRC_BT_A]   = i_events.base_timer_event_a;
      set[SRC_BT_B]   = i_events.base_timer_event_b;
      set[SRC_T0H]    = i_events.timer_zero_high_event;
      set[SRC_T1L]    = i_events.timer_one_low_event;
      set[SRC_T1H]    = i_events.timer_one_high_event;
      set[SRC_SYNC_SERIAL_ZERO_EVENT]   = i_events.sync_serial_zero_event;
      set[SRC_ARX]    = i_events.async_serial_event_rx;
      set[SRC_SERIAL_ONE_EVENT]   = i_events.serial_one_event;
      set[SRC_ATX]    = i_events.async_serial_event_tx;
      set[SRC_ADC]    = i_events.adc_event;
      set[SRC_T6]     = i_events.timer_six_event;
      set[SRC_T7]     = i_events.timer_seven_event;
      set[SRC_PORT0]  = i_events.port_zero_event;
      set[SRC_T4]     = i_events.timer_four_event;
      set[SRC_T5]     = i_events.timer_five_event;
      // Both pulse-width channels share one flag to keep 24 sources
      set[SRC_PWM]    = i_events.pulse_width_chan_a_event
                      | i_events.pulse_width_chan_b_event;

      // A new event beats a clear arriving in the same cycle
      state_d.flags = (state_q.flags & ~i_flag_clr) | set;

      // Level stack: one bit per level, nesting only upward
      svc = state_q.svc;
      cur = top_level(state_q.svc);
      if (i_irq_ack && state_q.core.req) begin
         unique case (state_q.core.level)
            MVIC_LVL_LOW:     svc[0] = 1'b1;
            MVIC_LVL_HIGH:    svc[1] = 1'b1;
            MVIC_LVL_HIGHEST: svc[2] = 1'b1;
            MVIC_LVL_NONE:    svc    = state_q.svc;
         endcase
         // Snapshot of the flags behind the vector just taken
         state_d.listing = state_q.flags
                         & VEC_MASK[state_q.vec_idx];
      end else if (i_irq_return) begin
         unique case (cur)
            MVIC_LVL_HIGHEST: svc[2] = 1'b0;
            MVIC_LVL_HIGH:    svc[1] = 1'b0;
            MVIC_LVL_LOW:     svc[0] = 1'b0;
            MVIC_LVL_NONE:    svc    = state_q.svc;
         endcase
      end
      state_d.svc = svc;

      // Drop the offer for a cycle around ack/return so the core never
      // sees a request judged against a stale level in service
      state_d.core.req      = arb_valid && !i_irq_ack && !i_irq_return;
      state_d.core.level    = arb_level;
      state_d.core.vec_addr = VEC_ADDR[arb_idx];
      state_d.vec_idx       = arb_idx;

      // Pins zero and one only wake from hold when level detected
      state_d.wake = i_hold_mode
                   & ((i_ext_level_mode[0] & pin[5])
                    | (i_ext_level_mode[1] & pin[4])
                    | state_q.flags[SRC_EXT2]
                    | state_q.flags[SRC_EXT4]
                    | state_q.flags[SRC_EXT5]
                    | state_q.flags[SRC_PORT0]);
   end

   always_ff @(posedge i_ref_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         state_q <= STATE_RST;
      end else begin
         state_q <= state_d;
      end
   end

   assign o_core                = state_q.core;
   assign o_source_flag_listing = state_q.listing;
   assign o_flags               = state_q.flags;
   assign o_in_service          = state_q.svc;
   assign o_hold_wake           = state_q.wake;

endmodule

// File: tb/mvic_checker.sv
/* Port assertions for the nested interrupt controller.
 Bound to mvic_top; one clock, asynchronous active-low reset. */
`timescale 1ns/1ps
module mvic_checker (
   input wire logic                         i_ref_clk,
   input wire logic                         i_resetn,
   input wire mvic_pkg::mvic_events_type    i_events,
   input wire logic                         i_irq_ack,
   input wire logic                         i_irq_return,
   input wire mvic_pkg::mvic_core_req_type  o_core,
   input wire logic [mvic_pkg::SRC_N-1:0]   o_source_flag_listing,
   input wire logic [mvic_pkg::SRC_N-1:0]   o_flags,
   input wire logic [mvic_pkg::LVL_N-1:0]   o_in_service,
   input wire logic                         i_hold_mode,
   input wire logic [1:0]                   i_ext_level_mode,
   input wire logic                         o_hold_wake
);
   import mvic_pkg::*;
   default clocking cb @(posedge i_ref_clk); endclocking
   default disable iff (!i_resetn);
   sequence s_take;
      o_core.req && i_irq_ack;
   endsequence
   // Lone event into a quiet controller, nothing else arriving behind it
   sequence s_lone_t0h;
      (i_events == 19'h20000 && o_flags == 24'h0 && o_in_service == 3'h0)
      ##1 (i_events == 19'h0);
   endsequence
   AST_TAKE_LOW:
      assert property (s_take ##0 (o_core.level == MVIC_LVL_LOW &&
         o_in_service == 3'h0) |=> o_in_service == 3'h1)
      else $error("low take did not mark low in service");
   AST_NEST_ABOVE:
      assert property (o_core.req |-> !o_in_service[2] &&
         !(o_in_service[1] && o_core.level != MVIC_LVL_HIGHEST) &&
         !(o_in_service[0] && o_core.level == MVIC_LVL_LOW))
      else $error("offer not above level in service");
   AST_TAKE_DROPS:
      assert property (s_take |=> !o_core.req)
      else $error("offer still up after take");
   AST_LISTING:
      assert property (s_take |=> o_source_flag_listing != 24'h0 &&
         (o_source_flag_listing & ~$past(o_flags)) == 24'h0)
      else $error("listing not drawn from pending flags");
   AST_PIN_LEVEL:
      assert property (o_core.req && o_core.vec_addr inside {20'h3, 20'hb}
         |-> o_core.level != MVIC_LVL_HIGH)
      else $error("pin vector offered at high");
   AST_SHARED_LEVEL:
      assert property (o_core.req && !(o_core.vec_addr inside {20'h3,
         20'hb}) |-> o_core.level inside {MVIC_LVL_LOW, MVIC_LVL_HIGH})
      else $error("shared vector offered at wrong level");
   AST_VEC_RANGE:
      assert property (o_core.req |-> o_core.vec_addr[2:0] == 3'h3 &&
         o_core.vec_addr <= 20'h4b)
      else $error("offered vector address off the table");
   AST_T0H_OFFER:
      assert property (s_lone_t0h |=> o_core.req &&
         o_core.vec_addr == 20'h23)
      else $error("timer zero high event not offered at 23h");
   AST_RETURN_POP:
      assert property (i_irq_return && !(o_core.req && i_irq_ack) &&
         o_in_service == 3'h6 |=> o_in_service == 3'h2)
      else $error("return did not pop top level");
   AST_FLAG_SET:
      assert property (i_events.adc_event |=> o_flags[SRC_ADC])
      else $error("converter event did not set its flag");
   AST_WAKE_HOLD_ONLY:
      assert property (!i_hold_mode |=> !o_hold_wake)
      else $error("wake raised outside hold");
   AST_WAKE_EDGE_PINS:
      assert property (i_hold_mode && i_ext_level_mode == 2'h0 |=>
         o_hold_wake == |($past(o_flags) & 24'h100094))
      else $error("wake from hold not matching edge-mode sources");
endmodule
bind mvic_top mvic_checker i_mvic_checker (
   .i_ref_clk             (i_ref_clk),
   .i_resetn              (i_resetn),
   .i_events              (i_events),
   .i_irq_ack             (i_irq_ack),
   .i_irq_return          (i_irq_return),
   .o_core                (o_core),
   .o_source_flag_listing (o_source_flag_listing),
   .o_flags               (o_flags),
   .o_in_service          (o_in_service),
   .i_hold_mode           (i_hold_mode),
   .i_ext_level_mode      (i_ext_level_mode),
   .o_hold_wake           (o_hold_wake)
);

// File: tb/mvic_core_model.sv
/* Core vectoring side: takes a standing offer after a set delay and
 registers a bench command as the return strobe, one cycle later.
 Assumes the controller's clock and reset. */
`timescale 1ns/1ps
module mvic_core_model (
   input  wire logic                         i_ref_clk,
   input  wire logic                         i_resetn,
   input  wire mvic_pkg::mvic_core_req_type  i_core,
   input  wire logic                         i_ack_en,
   input  wire logic [3:0]                   i_ack_delay,
   input  wire logic                         i_ret_cmd,
   output logic                              o_irq_ack,
   output logic                              o_irq_return
);
   import mvic_pkg::*;
   logic [3:0] wait_q;
   // Never acks twice in a row: the offer is down after a take anyway
   always_ff @(posedge i_ref_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         o_irq_ack <= 1'b0;
         o_irq_return <= 1'b0;
         wait_q <= 4'h0;
      end else begin
         o_irq_return <= i_ret_cmd;
         o_irq_ack <= 1'b0;
         wait_q <= 4'h0;
         if (i_core.req && i_ack_en && !o_irq_ack) begin
            if (wait_q >= i_ack_delay) begin
               o_irq_ack <= 1'b1;
            end else begin
               wait_q <= wait_q + 4'h1;
            end
         end
      end
   end
endmodule

// File: tb/mvic_top_tb.sv
/* Self-checking bench for the nested interrupt controller.
 Inputs change on falling edges; the core model takes offers. */
`timescale 1ns/1ps
module mvic_top_tb;
   import mvic_pkg::*;
   logic              clk, rstn, ack_en, ret_cmd, irq_ack, irq_ret;
   logic [3:0]        ack_dly;
   logic [1:0]        lvl_mode;
   logic              hold, wake;
   mvic_ext_type      pins;
   mvic_events_type   ev;
   logic [VEC_N-1:0]  lvl_sel;
   logic [SRC_N-1:0]  clr, listing, flags;
   logic [LVL_N-1:0]  svc;
   mvic_core_req_type core;
   int                n_mismatch, tests_run, cycles;
   // Per event field, first field first: vector low byte, source bit
   localparam logic [7:0] EV_VEC [19] = '{8'h13, 8'h23, 8'h2b, 8'h2b,
      8'h13, 8'h1b, 8'h1b, 8'h33, 8'h33, 8'h3b, 8'h3b, 8'h43, 8'h4b,
      8'h4b, 8'h43, 8'h43, 8'h4b, 8'h4b, 8'h4b};
   localparam int EV_SRC [19] = '{3, 10, 11, 12, 5, 8, 9, 13, 14, 15, 16,
      17, 21, 22, 18, 19, 20, 23, 23};
   // Pins two, three, four, five: vector low byte, source bit
   localparam logic [7:0] PIN_VEC [4] = '{8'h13, 8'h1b, 8'h13, 8'h1b};
   localparam int PIN_SRC [4] = '{2, 6, 4, 7};
   mvic_top i_mvic_top (.i_ref_clk(clk), .i_resetn(rstn),
      .i_ext_pins(pins), .i_ext_level_mode(lvl_mode), .i_events(ev),
      .i_level_sel(lvl_sel), .i_flag_clr(clr), .i_irq_ack(irq_ack),
      .i_irq_return(irq_ret), .i_hold_mode(hold), .o_core(core),
      .o_source_flag_listing(listing), .o_flags(flags),
      .o_in_service(svc), .o_hold_wake(wake));
   mvic_core_model i_mvic_core_model (.i_ref_clk(clk), .i_resetn(rstn),
      .i_core(core), .i_ack_en(ack_en), .i_ack_delay(ack_dly),
      .i_ret_cmd(ret_cmd), .o_irq_ack(irq_ack), .o_irq_return(irq_ret));
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   task automatic end_sim;
      $display("checks %0d mismatches %0d", tests_run, n_mismatch);
      if (n_mismatch == 0 && tests_run > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   always @(posedge clk) begin
      cycles++;
      if (cycles == 5000) begin
         n_mismatch++;
         end_sim();
      end
   end
   task automatic check(input string what, input logic [23:0] got, exp);
      tests_run++;
      if (got !== exp) begin
         n_mismatch++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic pulse(input mvic_events_type e);
      ev = e;
      @(negedge clk);
      ev = '0;
   endtask
   task automatic wait_svc(input logic [2:0] exp);
      for (int k = 0; k < 20 && svc !== exp; k++) @(negedge clk);
      check("in_service", 24'(svc), 24'(exp));
   endtask
   task automatic serve(input logic [7:0] vec, input mvic_level_type lv,
                        input logic [23:0] src, input logic [2:0] s);
      for (int k = 0; k < 20 && core.req !== 1'b1; k++) @(negedge clk);
      check("vec_addr", 24'(core.vec_addr), 24'(vec));
      check("level", 24'(core.level), 24'(lv));
      ack_en = 1'b1;
      wait_svc(s);
      ack_en = 1'b0;
      check("listing", listing, src);
   endtask
   task automatic finish(input logic [23:0] src, input logic [2:0] s);
      clr = src;
      ret_cmd = 1'b1;
      @(negedge clk);
      clr = '0;
      ret_cmd = 1'b0;
      wait_svc(s);
   endtask
   task automatic idle_check;
      repeat (4) @(negedge clk);
      check("req", 24'(core.req), 24'h0);
   endtask
   task automatic t_reset;
      check("req", 24'(core.req), 24'h0);
      check("flags", flags, 24'h0);
      check("listing", listing, 24'h0);
   endtask
   task automatic t_sources;
      for (int j = 0; j < 19; j++) begin
         pulse(19'h40000 >> j);
         serve(EV_VEC[j], MVIC_LVL_LOW, 24'h1 << EV_SRC[j], 3'h1);
         finish(24'h1 << EV_SRC[j], 3'h0);
      end
   endtask
   task automatic t_nesting;
      lvl_sel = 10'h101;
      ack_dly = 4'h3;
      pulse(19'h40084);
      serve(8'h43, MVIC_LVL_HIGH, 24'h020000, 3'h2);
      idle_check();
      pins.zero = 1'b1;
      serve(8'h03, MVIC_LVL_HIGHEST, 24'h000001, 3'h6);
      pins.zero = 1'b0;
      finish(24'h000001, 3'h2);
      idle_check();
      finish(24'h020000, 3'h0);
      serve(8'h13, MVIC_LVL_LOW, 24'h000008, 3'h1);
      idle_check();
      finish(24'h000008, 3'h0);
      serve(8'h4b, MVIC_LVL_LOW, 24'h100000, 3'h1);
      finish(24'h100000, 3'h0);
   endtask
   task automatic t_pins;
      // Pins two to five in turn, edge detected after the synchroniser
      for (int p = 0; p < 4; p++) begin
         pins = 6'h08 >> p;
         serve(PIN_VEC[p], MVIC_LVL_LOW, 24'h1 << PIN_SRC[p], 3'h1);
         pins = '0;
         finish(24'h1 << PIN_SRC[p], 3'h0);
      end
   endtask
   task automatic t_wake;
      // Edge-mode pin zero sets its flag but must not wake from hold
      hold = 1'b1;
      pins.zero = 1'b1;
      repeat (5) @(negedge clk);
      check("flags", flags, 24'h000001);
      check("wake", 24'(wake), 24'h0);
      // Level mode re-sets the flag against a clear and wakes
      lvl_mode = 2'h1;
      clr = 24'h000001;
      @(negedge clk);
      clr = '0;
      @(negedge clk);
      check("flags", flags, 24'h000001);
      check("wake", 24'(wake), 24'h1);
      {pins, lvl_mode, hold} = '0;
      clr = 24'h000001;
      @(negedge clk);
      clr = '0;
      repeat (3) @(negedge clk);
      check("flags", flags, 24'h0);
      check("wake", 24'(wake), 24'h0);
   endtask
   initial begin
      {rstn, ack_en, ret_cmd, ack_dly, pins, ev, lvl_sel, clr} = '0;
      {lvl_mode, hold} = '0;
      repeat (2) @(negedge clk);
      rstn = 1'b1;
      @(negedge clk);
      t_reset();
      t_sources();
      t_pins();
      t_wake();
      t_nesting();
      end_sim();
   end
endmodule
